// File: hw/firsr_top.sv
// Four-channel 64-tap decimating FIR with coefficient reload and register port
`timescale 1ns/1ps
`default_nettype none
`include "firsr_defines.svh"
module firsr_top (
  // Clock, reset, enable
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_ce,
  // Sample stream
  input  wire firsr_pkg::firsr_data_t   i_din,
  input  wire logic                    i_inpvalid,
  input  wire logic                    i_ibstart,
  output firsr_pkg::firsr_acc_t         o_dout,
  output logic                         o_outvalid,
  output logic                         o_obstart,
  output logic                         o_rfi,
  // Coefficient load
  input  wire firsr_pkg::firsr_coef_t   i_coeffin,
  input  wire logic                    i_coeffwe,
  input  wire logic                    i_coeffset,
  // Rate factor
  input  wire firsr_pkg::firsr_factor_t i_dfactor,
  input  wire logic                    i_factorset,
  // Wishbone slave
  input  wire logic                    i_wb_cyc,
  input  wire logic                    i_wb_stb,
  input  wire logic                    i_wb_we,
  input  wire logic [7:0]              i_wb_adr,
  input  wire logic [3:0]              i_wb_sel,
  input  wire logic [31:0]             i_wb_dat,
  output logic [31:0]                  o_wb_dat,
  output logic                         o_wb_ack
);
  import firsr_pkg::*;

  // Read side: tap index to {zero, address}
  function automatic logic [6:0] firsr_coef_rd(input logic [5:0] k, input logic [2:0] m);
    logic [5:0] j;
    j = (k > `FIRSR_CENTER) ? (`FIRSR_LAST_TAP - k) : k;
    if (!m[`FIRSR_CTRL_REORD]) begin
      firsr_coef_rd = {1'b0, k};
    end else if (m[`FIRSR_CTRL_HB]) begin
      firsr_coef_rd = (j == `FIRSR_CENTER) ? {1'b0, `FIRSR_HB_CTR_ADDR} :
                      {j[0], 1'b0, j[5:1]};
    end else if (m[`FIRSR_CTRL_SYM]) begin
      firsr_coef_rd = {1'b0, j};
    end else begin
      firsr_coef_rd = {1'b0, k};
    end
  endfunction : firsr_coef_rd

  // Load side: supplied position to {keep, address}
  function automatic logic [6:0] firsr_coef_wr(input logic [5:0] p, input logic [2:0] m);
    if (!m[`FIRSR_CTRL_REORD]) begin
      firsr_coef_wr = {1'b1, p};
    end else if (m[`FIRSR_CTRL_HB]) begin
      firsr_coef_wr = (p == `FIRSR_CENTER) ? {1'b1, `FIRSR_HB_CTR_ADDR} :
                      {(p < `FIRSR_CENTER) && !p[0], 1'b0, p[5:1]};
    end else if (m[`FIRSR_CTRL_SYM]) begin
      firsr_coef_wr = {p <= `FIRSR_CENTER, p};
    end else begin
      firsr_coef_wr = {1'b1, p};
    end
  endfunction : firsr_coef_wr

  firsr_state_t  state_q;
  firsr_state_t  state_d;
  logic          rfi_q;
  logic          rfi_was_q;
  logic [1:0]    ch_q;
  logic [1:0]    cur_ch_q;
  logic [5:0]    wptr_q [0:3];
  logic [1:0]    phase_q [0:3];
  logic [5:0]    tap_q;
  firsr_acc_t    acc_q;
  firsr_factor_t factor_q;
  logic [2:0]    hold_q;
  logic          bank_q;
  logic          loaded_q;
  logic [5:0]    widx_q;
  logic [2:0]    ctrl_q;
  logic          ack_q;
  logic [31:0]   rdat_q;
  firsr_acc_t    dout_q;
  logic          outvalid_q;
  logic          obstart_q;
  firsr_data_t   samp_mem [0:255];
  logic [255:0]  hist_vld_q;

  // Stream decode
  wire [1:0]  in_ch    = i_ibstart ? 2'h0 : ch_q;
  wire        accept   = (state_q == FIRSR_ST_IDLE) && rfi_was_q && i_inpvalid;
  wire [1:0]  eff_fac  = (factor_q == 2'h0) ? 2'h1 : factor_q;
  wire        compute  = accept && (phase_q[in_ch] == eff_fac - 2'h1);
  wire [5:0]  wr_ptr   = wptr_q[in_ch] + 6'h01;
  wire        last_tap = (tap_q == `FIRSR_LAST_TAP);

  // Multiply-accumulate path, always on the committed bank
  wire [6:0]        rd_map = firsr_coef_rd(tap_q, ctrl_q);
  firsr_coef_t      coef_raw;
  // History slots read as zero until written since reset
  wire [7:0]        rd_idx = {cur_ch_q, wptr_q[cur_ch_q] - tap_q};
  wire firsr_data_t samp   = hist_vld_q[rd_idx] ? samp_mem[rd_idx] : 16'h0000;
  wire firsr_coef_t coef   = rd_map[6] ? 16'h0000 : coef_raw;
  wire [31:0]       prod   = $signed(samp) * $signed(coef);
  wire firsr_acc_t  acc_n  = acc_q + {{6{prod[31]}}, prod};

  // Coefficient load decode
  wire [6:0]  wr_map  = firsr_coef_wr(widx_q, ctrl_q);
  wire        coef_we = i_coeffwe && wr_map[6];

  // Register port decode
  wire        wb_req   = i_wb_cyc && i_wb_stb && !ack_q;
  wire        sel_ctrl = (i_wb_adr == `FIRSR_CTRL_OFS);
  wire        sel_stat = (i_wb_adr == `FIRSR_STAT_OFS);
  wire        ctrl_wr  = i_wb_cyc && i_wb_stb && i_wb_we && ack_q && sel_ctrl && i_wb_sel[0];
  wire [31:0] stat_val = {26'h0, factor_q, 1'b0, bank_q, rfi_q, loaded_q};
  wire [31:0] rd_val   = sel_ctrl ? {29'h0, ctrl_q} : sel_stat ? stat_val : 32'h0;

  always_comb begin
    state_d = state_q;
    case (state_q)
      FIRSR_ST_IDLE: state_d = compute ? FIRSR_ST_MAC : FIRSR_ST_IDLE;
      FIRSR_ST_MAC:  state_d = last_tap ? FIRSR_ST_IDLE : FIRSR_ST_MAC;
      default:       state_d = FIRSR_ST_IDLE;
    endcase
  end

  // Ready toggles so that a sample follows one high cycle; held off until a set is committed or while holding
  wire rfi_d = (state_d == FIRSR_ST_IDLE) && loaded_q && (hold_q == 3'h0)
               && !i_factorset && !rfi_q;

  firsr_coef_mem u_coef_mem (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_we    (coef_we),
    .i_wbank (~bank_q),
    .i_waddr (wr_map[5:0]),
    .i_wdata (i_coeffin),
    .i_rbank (bank_q),
    .i_raddr (rd_map[5:0]),
    .o_rdata (coef_raw)
  );

  always_ff @(posedge i_clk) begin
    if (i_ce && accept) begin
      samp_mem[{in_ch, wr_ptr}] <= i_din;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q   <= FIRSR_ST_IDLE;
      rfi_q     <= 1'b0;
      rfi_was_q <= 1'b0;
      ch_q      <= 2'h0;
      cur_ch_q  <= 2'h0;
      tap_q     <= 6'h00;
      acc_q     <= 38'h0;
      hist_vld_q <= 256'h0;
      for (int i = 0; i < 4; i++) begin
        wptr_q[i]  <= 6'h00;
        phase_q[i] <= 2'h0;
      end
    end else if (i_ce) begin
      state_q   <= state_d;
      rfi_q     <= rfi_d;
      rfi_was_q <= rfi_q;
      if (accept) begin
        ch_q          <= in_ch + 2'h1;
        wptr_q[in_ch] <= wr_ptr;
        hist_vld_q[{in_ch, wr_ptr}] <= 1'b1;
        cur_ch_q      <= in_ch;
        tap_q         <= 6'h00;
        acc_q         <= 38'h0;
      end
      if (state_q == FIRSR_ST_MAC) begin
        tap_q <= tap_q + 6'h01;
        acc_q <= acc_n;
      end
      if (i_factorset) begin
        for (int i = 0; i < 4; i++) begin
          phase_q[i] <= 2'h0;
        end
      end else if (accept) begin
        phase_q[in_ch] <= compute ? 2'h0 : phase_q[in_ch] + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dout_q     <= 38'h0;
      outvalid_q <= 1'b0;
      obstart_q  <= 1'b0;
    end else if (i_ce) begin
      outvalid_q <= (state_q == FIRSR_ST_MAC) && last_tap;
      obstart_q  <= (state_q == FIRSR_ST_MAC) && last_tap && (cur_ch_q == 2'h0);
      if ((state_q == FIRSR_ST_MAC) && last_tap) begin
        dout_q <= acc_n;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      factor_q <= `FIRSR_FACTOR_RST;
      hold_q   <= 3'h0;
    end else if (i_ce) begin
      if (i_factorset) begin
        factor_q <= i_dfactor;
        hold_q   <= `FIRSR_HOLD_CYC;
      end else if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bank_q   <= 1'b0;
      loaded_q <= 1'b0;
      widx_q   <= 6'h00;
    end else if (i_ce) begin
      if (!i_coeffwe) begin
        widx_q <= 6'h00;
      end else if (widx_q != `FIRSR_LAST_TAP) begin
        widx_q <= widx_q + 6'h01;
      end
      if (i_coeffset) begin
        bank_q   <= ~bank_q;
        loaded_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= `FIRSR_CTRL_RST;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else if (i_ce) begin
      ack_q  <= wb_req;
      rdat_q <= rd_val;
      if (ctrl_wr) begin
        ctrl_q <= i_wb_dat[2:0];
      end
    end
  end

  assign o_dout     = dout_q;
  assign o_outvalid = outvalid_q;
  assign o_obstart  = obstart_q;
  assign o_rfi      = rfi_q;
  assign o_wb_dat   = rdat_q;
  assign o_wb_ack   = ack_q;
endmodule : firsr_top
`default_nettype wire

// File: hw/firsr_defines.svh
// Constants for the FIR stream and coefficient reload block
// Summary of operation
// - The block-start output rises in the same cycle as the channel 0 output sample.
// - The new decimation factor is captured from the factor input while its strobe is high.
// - After a factor change ready drops for some cycles, then the new factor applies.
// - One single-cycle commit pulse after the batch switches the filter to the new set.
// - Ready stays low from reset until the first commit pulse.
// - With reordering the filter takes natural tap order and places values itself.
// - With reordering and symmetry only the first half up to the centre tap is kept.
// - With reordering and half band odd positions except the centre, and all past the centre, are dropped.
// - A sample is taken only when input valid is high, otherwise data is ignored.
// - Output valid is high exactly in the cycles where the output carries a result.
// - The active-low reset returns all state except the sample and coefficient memories to its initial value asynchronously.
`ifndef FIRSR_DEFINES_SVH
`define FIRSR_DEFINES_SVH
`define FIRSR_LAST_TAP    6'h3F
`define FIRSR_CENTER      6'h1F
`define FIRSR_HB_CTR_ADDR 6'h10
`define FIRSR_HOLD_CYC    3'h4
`define FIRSR_FACTOR_RST  2'h2
`define FIRSR_CTRL_RST    3'h0
`define FIRSR_CTRL_OFS    8'h00
`define FIRSR_STAT_OFS    8'h04
`define FIRSR_CTRL_REORD  0
`define FIRSR_CTRL_SYM    1
`define FIRSR_CTRL_HB     2
`define FIRSR_STAT_LOADED 0
`define FIRSR_STAT_RFI    1
`define FIRSR_STAT_BANK   2
`define FIRSR_STAT_FACT   4
`endif

// File: hw/firsr_pkg.sv
// Types for the FIR stream and coefficient reload block
package firsr_pkg;
  typedef logic [15:0] firsr_data_t;
  typedef logic [15:0] firsr_coef_t;
  typedef logic [37:0] firsr_acc_t;
  typedef logic [1:0]  firsr_factor_t;
  typedef enum logic [1:0] {
    FIRSR_ST_IDLE = 2'b01,
    FIRSR_ST_MAC  = 2'b10
  } firsr_state_t;
endpackage : firsr_pkg

// File: hw/firsr_coef_mem.sv
// Two-bank coefficient store, one bank active while the other loads
`timescale 1ns/1ps
`default_nettype none
module firsr_coef_mem (
  // Clock
  input  wire logic                  i_clk,
  input  wire logic                  i_ce,
  // Write port
  input  wire logic                  i_we,
  input  wire logic                  i_wbank,
  input  wire logic [5:0]            i_waddr,
  input  wire firsr_pkg::firsr_coef_t i_wdata,
  // Read port
  input  wire logic                  i_rbank,
  input  wire logic [5:0]            i_raddr,
  output firsr_pkg::firsr_coef_t      o_rdata
);
  import firsr_pkg::*;
  firsr_coef_t mem [0:127];
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[{i_wbank, i_waddr}] <= i_wdata;
    end
  end
  assign o_rdata = mem[{i_rbank, i_raddr}];
endmodule : firsr_coef_mem
`default_nettype wire

// File: tb/firsr_top_sva.sv
// Port checks for the FIR stream block
`timescale 1ns/1ps
`default_nettype none
module firsr_top_sva (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_coeffset,
  input wire logic i_factorset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_outvalid,
  input wire logic o_obstart,
  input wire logic o_rfi,
  input wire logic o_wb_ack
);
  logic seen_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) seen_q <= 1'b0;
    else if (i_coeffset && i_ce) seen_q <= 1'b1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_rfi_commit: assert property (!seen_q |-> !o_rfi) else $error("rfi early");
  chk_obstart_valid: assert property (o_obstart |-> o_outvalid) else $error("lone obstart");
  chk_outvalid_one: assert property (o_outvalid && i_ce |=> !o_outvalid)
    else $error("outvalid long");
  chk_rfi_pulse: assert property (o_rfi && i_ce |=> !o_rfi) else $error("rfi long");
  chk_factor_hold: assert property (i_factorset && i_ce |=> !o_rfi [*4])
    else $error("rfi in factor hold");
  chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce |=> o_wb_ack)
    else $error("ack late");
  chk_ack_pulse: assert property (o_wb_ack && i_ce |=> !o_wb_ack) else $error("ack long");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !i_resetn |-> !o_rfi && !o_outvalid && !o_wb_ack) else $error("outputs in reset");
endmodule : firsr_top_sva
bind firsr_top firsr_top_sva firsr_top_sva_inst (.i_clk, .i_resetn, .i_ce, .i_coeffset,
  .i_factorset, .i_wb_cyc, .i_wb_stb, .o_outvalid, .o_obstart, .o_rfi, .o_wb_ack);
`default_nettype wire

// File: tb/firsr_partner.sv
// Coefficient loader and sample supplier
`timescale 1ns/1ps
`default_nettype none
module firsr_partner (
  input  wire logic        i_clk,
  input  wire logic        i_rfi,
  input  wire logic        i_go,
  input  wire logic [7:0]  i_nsamp,
  input  wire logic        i_load,
  input  wire logic [6:0]  i_nload,
  input  wire logic [15:0] i_coef,
  output logic [15:0]      o_din,
  output logic             o_inpvalid,
  output logic             o_ibstart,
  output logic [15:0]      o_coeffin,
  output logic             o_coeffwe,
  output logic             o_busy
);
  logic [7:0] left_q = 8'h00;
  logic [6:0] cnt_q = 7'h00;
  logic [1:0] ch_q = 2'h0;
  initial begin
    {o_inpvalid, o_ibstart, o_coeffwe} = 3'h0;
    o_din = 16'h0000;
    o_coeffin = 16'h0000;
  end
  assign o_busy = (left_q != 8'h00) || o_coeffwe;
  always @(posedge i_clk) begin
    o_inpvalid <= 1'b0;
    o_ibstart <= 1'b0;
    o_din <= ~o_din;
    o_coeffin <= ~o_coeffin;
    if (i_go) left_q <= i_nsamp;
    else if (i_rfi && left_q != 8'h00) begin
      o_inpvalid <= 1'b1;
      o_ibstart <= (ch_q == 2'h0);
      o_din <= {5'h00, ch_q + 3'h1, 8'h00};
      ch_q <= ch_q + 2'h1;
      left_q <= left_q - 8'h01;
    end
    if (i_load) begin
      cnt_q <= i_nload;
      o_coeffwe <= 1'b1;
      o_coeffin <= i_coef;
    end else if (o_coeffwe) begin
      o_coeffin <= 16'h0000;
      cnt_q <= cnt_q - 7'h01;
      o_coeffwe <= (cnt_q != 7'h01);
    end
  end
endmodule : firsr_partner
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the FIR stream block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import firsr_pkg::*;
  logic clk = 1'b0, resetn = 1'b1, ce = 1'b1, cset = 1'b0, fset = 1'b0;
  logic go = 1'b0, load = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic inpvalid, ibstart, coeffwe, busy, outvalid, obstart, rfi, ack;
  logic [15:0] din, coeffin, coef = 16'h0000, exp_c = 16'h0000;
  logic [7:0] nsamp = 8'h00, adr = 8'h00;
  logic [6:0] nload = 7'h00;
  logic [1:0] fact = 2'h0, och = 2'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  firsr_acc_t dout;
  int err_total = 0, n_compared = 0, n_out = 0;
  always #10 clk = ~clk;
  firsr_top firsr_top_inst (.i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_din(din),
    .i_inpvalid(inpvalid), .i_ibstart(ibstart), .o_dout(dout), .o_outvalid(outvalid),
    .o_obstart(obstart), .o_rfi(rfi), .i_coeffin(coeffin), .i_coeffwe(coeffwe),
    .i_coeffset(cset), .i_dfactor(fact), .i_factorset(fset), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack));
  firsr_partner firsr_partner_inst (.i_clk(clk), .i_rfi(rfi), .i_go(go), .i_nsamp(nsamp),
    .i_load(load), .i_nload(nload), .i_coef(coef), .o_din(din), .o_inpvalid(inpvalid),
    .o_ibstart(ibstart), .o_coeffin(coeffin), .o_coeffwe(coeffwe), .o_busy(busy));
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [37:0] e, input logic [37:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic wait_on(input int n);
    if (n <= 0) begin
      err_total++;
      final_report();
    end
  endtask : wait_on
  always @(posedge clk) begin
    if (outvalid === 1'b1) begin
      check("dout", (38'(exp_c) * 38'(och + 3'h1)) << 8, dout);
      check("obstart", och == 2'h0, obstart);
      och <= och + 2'h1;
      n_out++;
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    for (i = 50; i > 0 && ack !== 1'b1; i--) @(posedge clk);
    if (ack !== 1'b1) @(posedge clk);
    wait_on(i);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic burst(input logic [7:0] n, input int outs);
    int i;
    n_out = 0;
    @(posedge clk);
    {go, nsamp} <= {1'b1, n};
    @(posedge clk);
    go <= 1'b0;
    for (i = 20000; i > 0 && (busy || n_out < outs); i--) @(posedge clk);
    wait_on(i);
    repeat (80) @(posedge clk);
    check("outputs", outs, n_out);
  endtask : burst
  task automatic load_set(input logic [15:0] c, input logic [6:0] n);
    @(posedge clk);
    {load, coef, nload} <= {1'b1, c, n};
    @(posedge clk);
    load <= 1'b0;
  endtask : load_set
  task automatic commit(input logic [15:0] c);
    int i;
    @(posedge clk);
    for (i = 200; i > 0 && coeffwe !== 1'b0; i--) @(posedge clk);
    wait_on(i);
    @(posedge clk);
    cset <= 1'b1;
    @(posedge clk);
    cset <= 1'b0;
    exp_c = c;
  endtask : commit
  task automatic sc_regs;
    check("rfi", 0, rfi);
    wb(0, 8'h00, 0); check("ctrl", 0, q);
    wb(1, 8'h08, 32'hFF); wb(0, 8'h08, 0); check("unmapped", 0, q);
    wb(1, 8'h04, 32'h33); wb(0, 8'h04, 0); check("status", 32'h20, q & 32'h33);
    wb(1, 8'h00, 32'h7); wb(0, 8'h00, 0); check("ctrl", 7, q);
    wb(1, 8'h00, 32'h0);
  endtask : sc_regs
  task automatic sc_first;
    load_set(16'h0003, 7'h40);
    commit(16'h0003);
    wb(0, 8'h04, 0); check("loaded", 1, q[0]);
    burst(8'h10, 8);
  endtask : sc_first
  task automatic sc_factor;
    @(posedge clk);
    {fact, fset} <= {2'h3, 1'b1};
    @(posedge clk);
    {fact, fset} <= {2'h1, 1'b0};
    wb(0, 8'h04, 0); check("factor", 3, q[5:4]);
    burst(8'h18, 8);
  endtask : sc_factor
  task automatic sc_reload;
    wb(1, 8'h00, 32'h3);
    load_set(16'h0005, 7'h20);
    burst(8'h10, 4);
    commit(16'h0005);
    burst(8'h18, 8);
  endtask : sc_reload
  task automatic sc_hband;
    wb(1, 8'h00, 32'h5);
    load_set(16'h0007, 7'h40);
    commit(16'h0007);
    burst(8'h18, 8);
  endtask : sc_hband
  task automatic sc_reset;
    logic v;
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    v = rfi;
    repeat (3) @(posedge clk);
    check("frozen rfi", v, rfi);
    ce <= 1'b1;
    resetn <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    check("reset rfi", 0, rfi);
    check("reset outvalid", 0, outvalid);
    resetn <= 1'b1;
    wb(0, 8'h04, 0); check("reset status", 32'h20, q);
    wb(0, 8'h00, 0); check("reset ctrl", 0, q);
    repeat (4) @(posedge clk);
    check("rfi unloaded", 0, rfi);
  endtask : sc_reset
  initial begin
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    sc_regs();
    sc_first();
    sc_factor();
    sc_reload();
    sc_hband();
    sc_reset();
    final_report();
  end
endmodule : testbench
`default_nettype wire
